// *** src/eifs_flag_cell.sv ***
/*
 * eifs_flag_cell: one request flag with edge detection and pin-function
 * switch detection for a single active-low interrupt pin.
 * assumes: level_in is already synchronised; func_in and pol_in are
 * register outputs on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module eifs_flag_cell (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // pin and configuration
    input  wire logic level_in,
    input  wire logic func_in,
    input  wire logic pol_in,
    // flag control
    input  wire logic clr_in,
    output logic      flag_out,
    output logic      set_out
);

    typedef struct packed {
        logic prev_level;
        logic prev_func;
        logic flag;
    } eifs_cell_t;

    eifs_cell_t state_ff;
    eifs_cell_t nxt_state;
    logic       fall;
    logic       rise;
    logic       edge_hit;
    logic       sw_on;
    logic       sw_off;
    logic       set_now;

    always_comb begin
        nxt_state  = state_ff;
        fall       = state_ff.prev_level & ~level_in;
        rise       = ~state_ff.prev_level & level_in;
        // pol 0 falling, pol 1 rising, only while function active
        edge_hit   = func_in & (pol_in ? rise : fall);
        // switching on while low with falling sense
        sw_on      = func_in & ~state_ff.prev_func & ~level_in
                     & ~pol_in;
        // switching off while low with rising sense
        sw_off     = ~func_in & state_ff.prev_func & ~level_in
                     & pol_in;
        set_now    = edge_hit | sw_on | sw_off;
        nxt_state.prev_level = level_in;
        nxt_state.prev_func  = func_in;
        // set wins over a clear in the same cycle
        nxt_state.flag = (state_ff.flag & ~clr_in) | set_now;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= '{prev_level: eifs_pkg::RST_PIN_LVL,
                          prev_func:  1'b0,
                          flag:       1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign flag_out = state_ff.flag;
    assign set_out  = set_now;

endmodule

`default_nettype wire

// *** src/eifs_pkg.sv ***
/*
 * eifs_pkg: register map, field layouts, reset values and bus codes for
 * the external interrupt pin-switch flag block.
 * assumes: AXI4-Lite slave with 32-bit data, one register per aligned word.
 */
package eifs_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int unsigned NUM_REQ  = 5;
    localparam int unsigned NUM_WAKE = 8;
    localparam int unsigned NUM_EVT  = NUM_REQ + NUM_WAKE;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned ADDR_W   = 6;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_FUNC_A     = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_FUNC_B     = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_WAKE_FUNC  = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_EDGE_POL   = 6'h0c;
    localparam logic [ADDR_W-1:0] OFS_REQ_FLAGS  = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_WAKE_FLAGS = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 6'h1c;
    localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL  = 6'h20;

    // ------------------------------------------------------------------
    // field layouts: which request pins each function register owns
    // ------------------------------------------------------------------
    localparam logic [NUM_REQ-1:0] FUNC_A_MASK = 5'h0e;
    localparam logic [NUM_REQ-1:0] FUNC_B_MASK = 5'h11;
    // status/mask: request pins in low bits, wakeup pins above
    localparam int unsigned EVT_WAKE_LSB = NUM_REQ;
    // pin level register: request pins low, wakeup pins above
    localparam int unsigned LVL_WAKE_LSB = 8;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [NUM_REQ-1:0]  RST_FUNC     = 5'h00;
    localparam logic [NUM_WAKE-1:0] RST_WAKE     = 8'h00;
    localparam logic [NUM_REQ-1:0]  RST_POL      = 5'h00;
    localparam logic [NUM_EVT-1:0]  RST_EVT      = 13'h0000;
    localparam logic                RST_PIN_LVL  = 1'b1;

    // ------------------------------------------------------------------
    // bus response codes
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** src/eifs_sync.sv ***
/*
 * eifs_sync: two-flop synchroniser for a bus of pin levels.
 * assumes: inputs are asynchronous to clk_in; reset release is synchronous.
 */
`timescale 1ns/1ps
`default_nettype none

module eifs_sync #(
    parameter int unsigned WIDTH     = 1,
    parameter logic        RST_LEVEL = 1'b1
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } eifs_sync_t;

    eifs_sync_t state_ff;
    eifs_sync_t nxt_state;

    // stage1 feeds stage2 only
    always_comb begin
        nxt_state        = state_ff;
        nxt_state.stage1 = async_in;
        nxt_state.stage2 = state_ff.stage1;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= {(2 * WIDTH){RST_LEVEL}};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out = state_ff.stage2;

endmodule

`default_nettype wire

// *** src/eifs_top.sv ***
/*
 * eifs_top: external interrupt request flags for five edge-selectable
 * request pins and eight falling-edge wakeup pins, with an AXI4-Lite
 * register slave, sticky event status, mask and one interrupt output.
 * assumes: pins are asynchronous and active low (idle high); one 10 MHz
 * clock; bus master keeps at most one read and one write outstanding.
 */
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module eifs_top #(
    parameter int unsigned ADDR_W = eifs_pkg::ADDR_W
) (
    // clock and reset
    input  wire logic                           mclk_in,
    input  wire logic                           nrst_in,
    // interrupt pins, active low
    input  wire logic [eifs_pkg::NUM_REQ-1:0]   ext_request_pin_n_in,
    input  wire logic [eifs_pkg::NUM_WAKE-1:0]  wakeup_pin_n_in,
    // flag and interrupt outputs
    output logic      [eifs_pkg::NUM_REQ-1:0]   ext_request_flag_out,
    output logic      [eifs_pkg::NUM_WAKE-1:0]  wakeup_request_flags_out,
    output logic                                irq_out,
    // axi4-lite write address
    input  wire logic                           s_axi_awvalid_in,
    output logic                                s_axi_awready_out,
    input  wire logic [ADDR_W-1:0]              s_axi_awaddr_in,
    // axi4-lite write data
    input  wire logic                           s_axi_wvalid_in,
    output logic                                s_axi_wready_out,
    input  wire logic [eifs_pkg::DATA_W-1:0]    s_axi_wdata_in,
    input  wire logic [3:0]                     s_axi_wstrb_in,
    // axi4-lite write response
    output logic                                s_axi_bvalid_out,
    input  wire logic                           s_axi_bready_in,
    output logic      [1:0]                     s_axi_bresp_out,
    // axi4-lite read address
    input  wire logic                           s_axi_arvalid_in,
    output logic                                s_axi_arready_out,
    input  wire logic [ADDR_W-1:0]              s_axi_araddr_in,
    // axi4-lite read data
    output logic                                s_axi_rvalid_out,
    input  wire logic                           s_axi_rready_in,
    output logic      [eifs_pkg::DATA_W-1:0]    s_axi_rdata_out,
    output logic      [1:0]                     s_axi_rresp_out
);

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                           aw_held;
        logic [ADDR_W-1:0]              aw_addr;
        logic                           w_held;
        logic [eifs_pkg::DATA_W-1:0]    w_data;
        logic [3:0]                     w_strb;
        logic                           bvalid;
        logic [1:0]                     bresp;
        logic                           rvalid;
        logic [eifs_pkg::DATA_W-1:0]    rdata;
        logic [1:0]                     rresp;
        logic [eifs_pkg::NUM_REQ-1:0]   func_a;
        logic [eifs_pkg::NUM_REQ-1:0]   func_b;
        logic [eifs_pkg::NUM_WAKE-1:0]  wake_func;
        logic [eifs_pkg::NUM_REQ-1:0]   edge_pol;
        logic [eifs_pkg::NUM_EVT-1:0]   status;
        logic [eifs_pkg::NUM_EVT-1:0]   mask;
        logic                           guard;
    } eifs_regs_t;

    // ------------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------------
    // kept outside the state struct: it alone resets on the raw pin
    logic [1:0] rst_pipe_ff;
    logic       rst_n;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_pipe_ff <= 2'h0;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe_ff[1];

    // ------------------------------------------------------------------
    // pin synchronisers and flag cells
    // ------------------------------------------------------------------
    logic [eifs_pkg::NUM_REQ-1:0]  req_level;
    logic [eifs_pkg::NUM_WAKE-1:0] wake_level;
    logic [eifs_pkg::NUM_EVT-1:0]  cell_level;
    logic [eifs_pkg::NUM_EVT-1:0]  cell_func;
    logic [eifs_pkg::NUM_EVT-1:0]  cell_pol;
    logic [eifs_pkg::NUM_EVT-1:0]  cell_clr;
    logic [eifs_pkg::NUM_EVT-1:0]  cell_flag;
    logic [eifs_pkg::NUM_EVT-1:0]  cell_set;
    logic [eifs_pkg::NUM_REQ-1:0]  req_func;
    logic [eifs_pkg::NUM_REQ-1:0]  req_clr;
    logic [eifs_pkg::NUM_WAKE-1:0] wake_clr;

    eifs_sync #(
        .WIDTH     (eifs_pkg::NUM_REQ),
        .RST_LEVEL (eifs_pkg::RST_PIN_LVL)
    ) u_req_sync (
        .clk_in   (mclk_in),
        .rst_n_in (rst_n),
        .async_in (ext_request_pin_n_in),
        .sync_out (req_level)
    );

    eifs_sync #(
        .WIDTH     (eifs_pkg::NUM_WAKE),
        .RST_LEVEL (eifs_pkg::RST_PIN_LVL)
    ) u_wake_sync (
        .clk_in   (mclk_in),
        .rst_n_in (rst_n),
        .async_in (wakeup_pin_n_in),
        .sync_out (wake_level)
    );

    eifs_regs_t state_ff;
    eifs_regs_t nxt_state;

    // each request pin is owned by exactly one of the two function regs
    assign req_func = (state_ff.func_a & eifs_pkg::FUNC_A_MASK)
                    | (state_ff.func_b & eifs_pkg::FUNC_B_MASK);

    assign cell_level = {wake_level, req_level};
    assign cell_func  = {state_ff.wake_func, req_func};
    // wakeup pins sense falling only, so only the 0-to-1 switch can set
    assign cell_pol   = {{eifs_pkg::NUM_WAKE{1'b0}}, state_ff.edge_pol};
    assign cell_clr   = {wake_clr, req_clr};

    genvar gi;
    generate
        for (gi = 0; gi < eifs_pkg::NUM_EVT; gi = gi + 1) begin : g_cell
            eifs_flag_cell u_cell (
                .clk_in   (mclk_in),
                .rst_n_in (rst_n),
                .level_in (cell_level[gi]),
                .func_in  (cell_func[gi]),
                .pol_in   (cell_pol[gi]),
                .clr_in   (cell_clr[gi]),
                .flag_out (cell_flag[gi]),
                .set_out  (cell_set[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------------
    function automatic logic [eifs_pkg::DATA_W-1:0] merge_bytes(
        input logic [eifs_pkg::DATA_W-1:0] old_val,
        input logic [eifs_pkg::DATA_W-1:0] new_val,
        input logic [3:0]                  strb
    );
        logic [eifs_pkg::DATA_W-1:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_val[8*b +: 8];
            end
        end
        return res;
    endfunction

    logic                          aw_take;
    logic                          w_take;
    logic                          ar_take;
    logic                          do_write;
    logic [eifs_pkg::DATA_W-1:0]   wr_val;
    logic [eifs_pkg::DATA_W-1:0]   zero_bits;
    logic [eifs_pkg::DATA_W-1:0]   rd_val;
    logic                          rd_ok;
    logic                          wr_ok;
    logic                          func_wr;
    logic                          clr_wr;
    logic                          status_rd;
    logic [ADDR_W-1:0]             wa;

    assign s_axi_awready_out = ~state_ff.aw_held & ~state_ff.bvalid;
    assign s_axi_wready_out  = ~state_ff.w_held & ~state_ff.bvalid;
    assign s_axi_arready_out = ~state_ff.rvalid;

    assign aw_take  = s_axi_awvalid_in & s_axi_awready_out;
    assign w_take   = s_axi_wvalid_in & s_axi_wready_out;
    assign ar_take  = s_axi_arvalid_in & s_axi_arready_out;
    assign do_write = state_ff.aw_held & state_ff.w_held & ~state_ff.bvalid;
    assign wa       = {state_ff.aw_addr[ADDR_W-1:2], 2'h0};

    always_comb begin
        wr_val    = merge_bytes({eifs_pkg::DATA_W{1'b0}}, state_ff.w_data,
                                state_ff.w_strb);
        // lanes not written count as ones, so they clear nothing
        zero_bits = ~merge_bytes({eifs_pkg::DATA_W{1'b1}}, state_ff.w_data,
                                 state_ff.w_strb);
        wr_ok     = 1'b1;
        func_wr   = 1'b0;
        clr_wr    = 1'b0;
        req_clr   = '0;
        wake_clr  = '0;
        unique case (wa)
            eifs_pkg::OFS_FUNC_A,
            eifs_pkg::OFS_FUNC_B,
            eifs_pkg::OFS_WAKE_FUNC: func_wr = do_write;
            eifs_pkg::OFS_REQ_FLAGS: begin
                clr_wr  = do_write;
                req_clr = zero_bits[eifs_pkg::NUM_REQ-1:0];
            end
            eifs_pkg::OFS_WAKE_FLAGS: begin
                clr_wr   = do_write;
                wake_clr = zero_bits[eifs_pkg::NUM_WAKE-1:0];
            end
            eifs_pkg::OFS_EDGE_POL,
            eifs_pkg::OFS_IRQ_STATUS,
            eifs_pkg::OFS_IRQ_MASK,
            eifs_pkg::OFS_PIN_LEVEL: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
        // a clear right after a function write leaves the flags alone
        if (!clr_wr || state_ff.guard) begin
            req_clr  = '0;
            wake_clr = '0;
        end
    end

    always_comb begin
        rd_val    = '0;
        rd_ok     = 1'b1;
        status_rd = 1'b0;
        unique case ({s_axi_araddr_in[ADDR_W-1:2], 2'h0})
            eifs_pkg::OFS_FUNC_A:
                rd_val[eifs_pkg::NUM_REQ-1:0] = state_ff.func_a;
            eifs_pkg::OFS_FUNC_B:
                rd_val[eifs_pkg::NUM_REQ-1:0] = state_ff.func_b;
            eifs_pkg::OFS_WAKE_FUNC:
                rd_val[eifs_pkg::NUM_WAKE-1:0] = state_ff.wake_func;
            eifs_pkg::OFS_EDGE_POL:
                rd_val[eifs_pkg::NUM_REQ-1:0] = state_ff.edge_pol;
            eifs_pkg::OFS_REQ_FLAGS:
                rd_val[eifs_pkg::NUM_REQ-1:0] =
                    cell_flag[eifs_pkg::NUM_REQ-1:0];
            eifs_pkg::OFS_WAKE_FLAGS:
                rd_val[eifs_pkg::NUM_WAKE-1:0] =
                    cell_flag[eifs_pkg::NUM_EVT-1:eifs_pkg::EVT_WAKE_LSB];
            eifs_pkg::OFS_IRQ_STATUS: begin
                rd_val[eifs_pkg::NUM_EVT-1:0] = state_ff.status;
                status_rd = ar_take;
            end
            eifs_pkg::OFS_IRQ_MASK:
                rd_val[eifs_pkg::NUM_EVT-1:0] = state_ff.mask;
            eifs_pkg::OFS_PIN_LEVEL: begin
                rd_val[eifs_pkg::NUM_REQ-1:0] = req_level;
                rd_val[eifs_pkg::LVL_WAKE_LSB +: eifs_pkg::NUM_WAKE] =
                    wake_level;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        if (aw_take) begin
            nxt_state.aw_held = 1'b1;
            nxt_state.aw_addr = s_axi_awaddr_in;
        end
        if (w_take) begin
            nxt_state.w_held = 1'b1;
            nxt_state.w_data = s_axi_wdata_in;
            nxt_state.w_strb = s_axi_wstrb_in;
        end
        if (do_write) begin
            nxt_state.aw_held = 1'b0;
            nxt_state.w_held  = 1'b0;
            nxt_state.bvalid  = 1'b1;
            nxt_state.bresp   = wr_ok ? eifs_pkg::RESP_OKAY
                                      : eifs_pkg::RESP_SLVERR;
            unique case (wa)
                eifs_pkg::OFS_FUNC_A:
                    nxt_state.func_a = wr_val[eifs_pkg::NUM_REQ-1:0]
                                       & eifs_pkg::FUNC_A_MASK;
                eifs_pkg::OFS_FUNC_B:
                    nxt_state.func_b = wr_val[eifs_pkg::NUM_REQ-1:0]
                                       & eifs_pkg::FUNC_B_MASK;
                eifs_pkg::OFS_WAKE_FUNC:
                    nxt_state.wake_func = wr_val[eifs_pkg::NUM_WAKE-1:0];
                eifs_pkg::OFS_EDGE_POL:
                    nxt_state.edge_pol = wr_val[eifs_pkg::NUM_REQ-1:0];
                eifs_pkg::OFS_IRQ_MASK:
                    nxt_state.mask = wr_val[eifs_pkg::NUM_EVT-1:0];
                default: nxt_state.mask = state_ff.mask;
            endcase
        end
        if (state_ff.bvalid && s_axi_bready_in) begin
            nxt_state.bvalid = 1'b0;
        end
        // any access but another function write disarms the guard
        if (do_write || ar_take) begin
            nxt_state.guard = func_wr;
        end
        if (ar_take) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rdata  = rd_val;
            nxt_state.rresp  = rd_ok ? eifs_pkg::RESP_OKAY
                                     : eifs_pkg::RESP_SLVERR;
        end else if (state_ff.rvalid && s_axi_rready_in) begin
            nxt_state.rvalid = 1'b0;
        end
        // read clears, but an event in the same cycle survives
        nxt_state.status = (status_rd ? eifs_pkg::RST_EVT : state_ff.status)
                           | cell_set;
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_ff           <= '0;
            state_ff.func_a    <= eifs_pkg::RST_FUNC;
            state_ff.func_b    <= eifs_pkg::RST_FUNC;
            state_ff.wake_func <= eifs_pkg::RST_WAKE;
            state_ff.edge_pol  <= eifs_pkg::RST_POL;
            state_ff.status    <= eifs_pkg::RST_EVT;
            state_ff.mask      <= eifs_pkg::RST_EVT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_bvalid_out = state_ff.bvalid;
    assign s_axi_bresp_out  = state_ff.bresp;
    assign s_axi_rvalid_out = state_ff.rvalid;
    assign s_axi_rdata_out  = state_ff.rdata;
    assign s_axi_rresp_out  = state_ff.rresp;

    assign ext_request_flag_out     = cell_flag[eifs_pkg::NUM_REQ-1:0];
    assign wakeup_request_flags_out =
        cell_flag[eifs_pkg::NUM_EVT-1:eifs_pkg::EVT_WAKE_LSB];
    assign irq_out = |(state_ff.status & state_ff.mask);

endmodule

`default_nettype wire

// *** test/eifs_pins.sv ***
/* eifs_pins: board side of the interrupt pins, pin 0 of each group driven.
   assumes: low_in comes from the bench on the clock. */
`timescale 1ns/1ps
`default_nettype none
module eifs_pins (
    input  wire logic       clk_in,
    input  wire logic       low_in,
    output logic      [4:0] req_pin_n_out,
    output logic      [7:0] wake_pin_n_out
);
    // idle pins held high, so no switch can raise a flag
    always @(posedge clk_in) begin
        req_pin_n_out  <= {4'hf, ~low_in};
        wake_pin_n_out <= {7'h7f, ~low_in};
    end
endmodule
`default_nettype wire

// *** test/eifs_props.sv ***
/* eifs_props: bus and flag timing checks for eifs_top.
   assumes: bound to eifs_top; only its ports are seen. */
`timescale 1ns/1ps
`default_nettype none
module eifs_props (
    input wire logic       mclk_in, nrst_in, irq_out,
    input wire logic [7:0] wakeup_pin_n_in, wakeup_request_flags_out,
    input wire logic [4:0] ext_request_flag_out,
    input wire logic       s_axi_awvalid_in, s_axi_awready_out,
    input wire logic       s_axi_wvalid_in, s_axi_wready_out,
    input wire logic       s_axi_bvalid_out, s_axi_bready_in,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic       s_axi_arvalid_in, s_axi_arready_out,
    input wire logic       s_axi_rvalid_out, s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    // pin lag through the two-flop synchroniser and the flag register is three samples
    wake_pin_set_a: assert property ((wakeup_request_flags_out
        & ~$past(wakeup_request_flags_out) & $past(wakeup_pin_n_in, 2)
        & $past(wakeup_pin_n_in, 3) & $past(wakeup_pin_n_in, 4)) == 8'h00)
        else $error("wakeup flag set while pin high");
    flag_clr_write_a: assert property (
        (|($past(wakeup_request_flags_out) & ~wakeup_request_flags_out))
        || (|($past(ext_request_flag_out) & ~ext_request_flag_out))
        |-> s_axi_bvalid_out) else $error("flag dropped without write");
    bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped");
    wr_busy_a: assert property (s_axi_bvalid_out
        |-> !s_axi_awready_out && !s_axi_wready_out) else $error("busy ready");
    rd_busy_a: assert property (s_axi_arready_out == !s_axi_rvalid_out)
        else $error("arready not inverse of rvalid");
    wr_latency_a: assert property (s_axi_awvalid_in && s_axi_awready_out
        && s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
        else $error("write response late");
    rd_cause_a: assert property ($rose(s_axi_rvalid_out)
        |-> $past(s_axi_arvalid_in && s_axi_arready_out))
        else $error("read data without request");
    cover property ($rose(irq_out));
    cover property ($rose(|wakeup_request_flags_out));
    cover property ($rose(|ext_request_flag_out));
endmodule
bind eifs_top eifs_props i_eifs_props (.mclk_in, .nrst_in, .irq_out,
    .wakeup_pin_n_in, .wakeup_request_flags_out, .ext_request_flag_out,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .s_axi_rdata_out);
`default_nettype wire

// *** test/tb_ext_irq_pin_switch_flags.sv ***
/* tb_ext_irq_pin_switch_flags: table of switch cases, then hand tests.
   assumes: eifs_top, eifs_pins and eifs_props compiled before. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module tb_ext_irq_pin_switch_flags;
    logic clk = 0, rst_n = 0, pl = 0, awv = 0, wv = 0, bre = 0, arv = 0;
    logic rre = 0, awr, wr_, bv, arr, rv, irq, k, p, a, b, e, ok;
    logic [5:0] aa = 0, ra = 0, fa, ga;
    logic [31:0] wd = 0, rd, v;
    logic [1:0] br, rr, bq, rq;
    logic [4:0] rf, rp;
    logic [7:0] wf, wp;
    int miscompares = 0;
    int checked = 0;
    // bits: wakeup, polarity, function before, after, flag expected
    localparam logic [4:0] ROWS [6] = '{5'b00011, 5'b01101, 5'b00100,
        5'b01010, 5'b10011, 5'b10100};
    eifs_pins i_eifs_pins (.clk_in(clk), .low_in(pl), .req_pin_n_out(rp),
        .wake_pin_n_out(wp));
    eifs_top i_eifs_top (.mclk_in(clk), .nrst_in(rst_n),
        .ext_request_pin_n_in(rp), .wakeup_pin_n_in(wp),
        .ext_request_flag_out(rf), .wakeup_request_flags_out(wf),
        .irq_out(irq), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_awaddr_in(aa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(bre), .s_axi_bresp_out(br), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_araddr_in(ra),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .s_axi_rdata_out(rd),
        .s_axi_rresp_out(rr));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic wrap_up;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [5:0] adr, input logic [31:0] d);
        begin
            @(posedge clk);
            aa <= adr; wd <= d; awv <= 1; wv <= 1; bre <= 1; ok = 0;
            for (int n = 0; n < 50 && !ok; n++) begin
                @(posedge clk);
                if (awv && awr) awv <= 0;
                if (wv && wr_) wv <= 0;
                if (bv) begin bre <= 0; bq = br; ok = 1; end
            end
            if (!ok) begin miscompares++; wrap_up(); end
        end
    endtask
    task automatic rdr(input logic [5:0] adr, output logic [31:0] d);
        begin
            @(posedge clk);
            ra <= adr; arv <= 1; rre <= 1; ok = 0;
            for (int n = 0; n < 50 && !ok; n++) begin
                @(posedge clk);
                if (arv && arr) arv <= 0;
                if (rv) begin rre <= 0; d = rd; rq = rr; ok = 1; end
            end
            if (!ok) begin miscompares++; wrap_up(); end
        end
    endtask
    initial begin
        step(2);
        rst_n <= 1;
        step(3);
        `CHK("reset flags", 14'h0, {rf, wf, irq})
        for (int i = 0; i < 6; i++) begin
            {k, p, a, b, e} = ROWS[i];
            fa = k ? 6'h08 : 6'h04;
            ga = k ? 6'h14 : 6'h10;
            wr(6'h0c, {31'h0, p});
            wr(fa, {31'h0, a});
            pl <= 1;
            step(5);
            rdr(ga, v);
            `CHK("edge flag", a & (k | ~p), v[0])
            wr(ga, 0);
            wr(fa, {31'h0, b});
            rdr(6'h20, v);
            rdr(ga, v);
            `CHK("switch flag", e, v[0])
            `CHK("flag pin", e, k ? wf[0] : rf[0])
            pl <= 0;
            step(5);
            wr(fa, 0);
            rdr(6'h20, v);
            wr(ga, 0);
        end
        wr(6'h0c, 0);
        pl <= 1;
        step(5);
        rdr(6'h18, v);
        wr(6'h1c, 32'h1fff);
        wr(6'h08, 32'h1);
        step(1);
        `CHK("irq raised", 1'b1, irq)
        wr(6'h14, 0);
        rdr(6'h14, v);
        `CHK("clear too soon", 1'b1, v[0])
        wr(6'h14, 32'hff);
        rdr(6'h14, v);
        `CHK("write one", 1'b1, v[0])
        wr(6'h14, 0);
        rdr(6'h14, v);
        `CHK("write zero", 1'b0, v[0])
        wr(6'h1c, 0);
        `CHK("irq masked", 1'b0, irq)
        wr(6'h1c, 32'h1fff);
        `CHK("irq unmasked", 1'b1, irq)
        rdr(6'h18, v);
        `CHK("irq cleared", 1'b0, irq)
        wr(6'h3c, 0);
        rdr(6'h3c, v);
        `CHK("bad address", 4'ha, {bq, rq})
        wrap_up();
    end
endmodule
`default_nettype wire
